// File: rtl/wrf_pkg.sv
// Shared constants, types and helpers of the weight report formatter.
package wrf_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int UPDATE_MS = 60;
  localparam int UPDATE_CYCLES_DEF = UPDATE_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_WORD1 = 8'h0c;
  localparam logic [7:0] OFS_WORD2 = 8'h10;
  localparam logic [7:0] OFS_DOUT = 8'h14;
  localparam logic [7:0] OFS_DIN = 8'h18;
  localparam logic [7:0] OFS_ASSIGN = 8'h1c;

  // ----------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------
  localparam int CFG_FMT_LSB = 0;
  localparam int CFG_ORD_LSB = 2;
  localparam logic [1:0] FMT_INTEGER = 2'h0;
  localparam logic [1:0] FMT_DIVISIONS = 2'h1;
  localparam logic [1:0] FMT_FLOAT = 2'h2;
  localparam logic [1:0] ORD_STANDARD = 2'h0;
  localparam logic [1:0] ORD_WORD_SWAP = 2'h1;
  localparam logic [1:0] ORD_BYTE_SWAP = 2'h2;
  localparam logic [1:0] ORD_DWORD_SWAP = 2'h3;
  localparam logic [1:0] FMT_RESET = FMT_INTEGER;
  localparam logic [1:0] ORD_RESET = ORD_STANDARD;

  // ----------------------------------------
  // Commands and indicators
  // ----------------------------------------
  localparam logic [15:0] CMD_FIRST = 16'h0001;
  localparam logic [15:0] CMD_NEXT = 16'h0002;
  localparam logic [15:0] CMD_CLEAR = 16'h0003;
  localparam logic [15:0] CMD_ADD_NET = 16'h0029;
  localparam logic [15:0] CMD_ADD_RATE = 16'h002e;
  localparam logic [7:0] ACK_FIRST = 8'h01;
  localparam logic [7:0] ACK_NEXT = 8'h02;
  localparam logic [7:0] ACK_LAST = 8'h03;
  localparam logic [7:0] IND_NET = 8'h01;
  localparam logic [7:0] IND_RATE = 8'h06;
  localparam logic [7:0] IND_NULL = 8'h1e;

  typedef enum logic [1:0] {
    FLD_NET = 2'b01,
    FLD_RATE = 2'b10
  } field_t;

  typedef enum logic [1:0] {
    MODE_SETUP = 2'b01,
    MODE_FIELD = 2'b10
  } mode_t;

  typedef struct packed {
    logic [31:0] digits;
    logic [31:0] divs;
    logic [31:0] fp;
  } field_src_t;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } words_t;

  function automatic logic [15:0] bswap16(input logic [15:0] w);
    bswap16 = {w[7:0], w[15:8]};
  endfunction

endpackage

// File: rtl/weight_encoder.sv
// Weight encoder: integer, divisions or single-precision words.
module weight_encoder
  import wrf_pkg::*;
(
  // Source and selection
  input wire field_src_t src,
  input wire logic [1:0] fmt,
  // Encoded words, high word first
  output words_t words,
  output logic single
);

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  // Only the low 16 bits are kept, so larger weights wrap to a negative
  // or meaningless word; floating point must be used for big scales.
  wire logic is_float = (fmt == FMT_FLOAT);
  wire logic [15:0] int_word = src.digits[15:0];
  wire logic [15:0] div_word = src.divs[15:0];
  wire logic [15:0] int_sel = (fmt == FMT_DIVISIONS) ? div_word : int_word;

  assign words.first = is_float ? src.fp[31:16] : int_sel;
  assign words.second = is_float ? src.fp[15:0] : 16'h0000;
  assign single = !is_float;

endmodule

// File: rtl/byte_order_unit.sv
// Byte and word arrangement of outgoing multi-byte values.
module byte_order_unit
  import wrf_pkg::*;
(
  // Value in natural order
  input wire words_t in_words,
  input wire logic single,
  input wire logic [1:0] order,
  // Value as sent
  output words_t out_words
);

  // ----------------------------------------
  // Arrangement
  // ----------------------------------------
  wire logic swap_bytes = (order == ORD_BYTE_SWAP) || (order == ORD_DWORD_SWAP);
  wire logic swap_words = !single && ((order == ORD_WORD_SWAP) ||
                                      (order == ORD_DWORD_SWAP));
  wire words_t byte_set = swap_bytes ?
    words_t'{first: bswap16(in_words.first), second: bswap16(in_words.second)} :
    in_words;

  assign out_words = swap_words ?
    words_t'{first: byte_set.second, second: byte_set.first} : byte_set;

endmodule

// File: rtl/weight_report_rotation_formatter.sv
// Top of the weight report formatter: commands, rotation, data block, discrete I/O.

// Overview of operation
// - Command 1 reports first field, ack 1.
// - First field sends net weight, indicator 1.
// - Command 2 acks 2, sends rate, indicator 6.
// - Held command value is not new.
// - Command 1 after 2 returns to net.
// - Refresh every 60 ms, never self-advance.
// - Integer, divisions, float; integer by default.
// - Integer: signed 16-bit displayed digits.
// - Divisions: signed increment count, controller scales.
// - Float: single precision, two words.
// - Integer and divisions carry no decimal point.
// - Oversized weight wraps in 16-bit encodings.
// - Four byte and word orderings selectable.
// - Integer 1355 bytes swap per ordering.
// - Float words and bytes swap per ordering.
// - Discrete I/O updates on converter sample.
// - Controller drives only unassigned outputs.
// - Command 3 clears the rotation.
// - Command 46 adds rate, 41 adds net.
module weight_report_rotation_formatter
  import wrf_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYCLES_DEF,
  parameter int DEPTH = 8,
  parameter int DIO_W = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Measured quantities
  input wire field_src_t net_src,
  input wire field_src_t rate_src,
  // Discrete I/O
  input wire logic adc_tick,
  input wire logic [DIO_W-1:0] local_out,
  input wire logic [DIO_W-1:0] din_pin,
  output logic [DIO_W-1:0] dout_pin
);

  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int TICK_W = $clog2(UPDATE_CYCLES + 1);

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire logic wr_cmd = wr && (addr == OFS_CMD);
  wire logic wr_cfg = wr && (addr == OFS_CFG);
  wire logic wr_dout = wr && (addr == OFS_DOUT);
  wire logic wr_assign = wr && (addr == OFS_ASSIGN);

  logic [15:0] cmd;
  logic [1:0] fmt;
  logic [1:0] order;
  logic [DIO_W-1:0] plc_dout;
  logic [DIO_W-1:0] assigned;

  // Bits owned by a local function keep their old value on a write.
  wire logic [DIO_W-1:0] next_plc_dout =
    (wdata[DIO_W-1:0] & ~assigned) | (plc_dout & assigned);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd <= 16'h0000;
      fmt <= FMT_RESET;
      order <= ORD_RESET;
      plc_dout <= '0;
      assigned <= '0;
    end else begin
      if (wr_cmd) begin
        cmd <= wdata;
      end
      if (wr_cfg) begin
        fmt <= wdata[CFG_FMT_LSB +: 2];
        order <= wdata[CFG_ORD_LSB +: 2];
      end
      if (wr_dout) begin
        plc_dout <= next_plc_dout;
      end
      if (wr_assign) begin
        assigned <= wdata[DIO_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Interface update cycle
  // ----------------------------------------
  logic [TICK_W-1:0] tick_cnt;
  wire logic tick_wrap = (tick_cnt == TICK_W'(UPDATE_CYCLES - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (tick_wrap) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // ----------------------------------------
  // Command detection
  // ----------------------------------------
  // The command word is only looked at once per update cycle, so a value
  // written and overwritten within one cycle is never seen.
  logic [15:0] cmd_prev;
  wire logic new_cmd = tick_wrap && (cmd != cmd_prev);
  wire logic do_first = new_cmd && (cmd == CMD_FIRST);
  wire logic do_next = new_cmd && (cmd == CMD_NEXT);
  wire logic do_clear = new_cmd && (cmd == CMD_CLEAR);
  wire logic do_add_net = new_cmd && (cmd == CMD_ADD_NET);
  wire logic do_add_rate = new_cmd && (cmd == CMD_ADD_RATE);
  wire logic do_add = do_add_net || do_add_rate;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_prev <= 16'h0000;
    end else if (tick_wrap) begin
      cmd_prev <= cmd;
    end
  end

  // ----------------------------------------
  // Rotation list
  // ----------------------------------------
  field_t list [DEPTH];
  logic [CNT_W-1:0] count;
  logic [IDX_W-1:0] idx;
  logic [7:0] ack;
  mode_t mode;

  wire logic list_full = (count == CNT_W'(DEPTH));
  wire logic list_empty = (count == '0);
  wire field_t add_field = do_add_rate ? FLD_RATE : FLD_NET;
  wire logic idx_last = ({1'b0, idx} + (CNT_W + 1)'(1)) >= {1'b0, count};
  wire logic [IDX_W-1:0] next_idx = idx_last ? '0 : idx + IDX_W'(1);
  wire logic [7:0] next_ack = (ack == ACK_LAST) ? ACK_FIRST : ack + 8'h01;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_list
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          list[gi] <= FLD_NET;
        end else if (do_add && !list_full && (count == CNT_W'(gi))) begin
          list[gi] <= add_field;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      idx <= '0;
      ack <= 8'h00;
      mode <= MODE_SETUP;
    end else if (do_first) begin
      idx <= '0;
      ack <= ACK_FIRST;
      mode <= MODE_FIELD;
    end else if (do_next) begin
      idx <= next_idx;
      ack <= ACK_NEXT;
      mode <= MODE_FIELD;
    end else if (do_clear) begin
      count <= '0;
      idx <= '0;
      ack <= ACK_FIRST;
      mode <= MODE_SETUP;
    end else if (do_add) begin
      if (!list_full) begin
        count <= count + CNT_W'(1);
      end
      ack <= next_ack;
      mode <= MODE_SETUP;
    end
  end

  // ----------------------------------------
  // Field selection
  // ----------------------------------------
  // During set-up, or with an empty list, a null value is reported.
  wire field_t cur_field = list[idx];
  wire logic show_null = (mode == MODE_SETUP) || list_empty;
  wire logic show_rate = !show_null && (cur_field == FLD_RATE);
  wire field_src_t null_src = '0;
  wire field_src_t cur_src = show_null ? null_src :
                             show_rate ? rate_src : net_src;
  wire logic [7:0] cur_ind = show_null ? IND_NULL :
                             show_rate ? IND_RATE : IND_NET;

  // ----------------------------------------
  // Encoding and ordering
  // ----------------------------------------
  words_t enc_words;
  words_t ord_words;
  logic enc_single;

  weight_encoder u_enc (
    .src(cur_src),
    .fmt(fmt),
    .words(enc_words),
    .single(enc_single)
  );

  byte_order_unit u_order (
    .in_words(enc_words),
    .single(enc_single),
    .order(order),
    .out_words(ord_words)
  );

  // The status word holds two bytes, so only the byte swap applies to it.
  wire logic stat_swap = (order == ORD_BYTE_SWAP) || (order == ORD_DWORD_SWAP);
  wire logic [15:0] stat_raw = {ack, cur_ind};
  wire logic [15:0] stat_ord = stat_swap ? bswap16(stat_raw) : stat_raw;

  // ----------------------------------------
  // Outgoing data block
  // ----------------------------------------
  // Values are sampled one cycle after the command is acted on, so the
  // acknowledge and the new field's data always leave together.
  logic refresh;
  logic [15:0] stat_out;
  words_t data_out;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      refresh <= 1'b0;
      stat_out <= 16'h0000;
      data_out <= '0;
    end else begin
      refresh <= tick_wrap;
      if (refresh) begin
        stat_out <= stat_ord;
        data_out <= ord_words;
      end
    end
  end

  // ----------------------------------------
  // Discrete I/O
  // ----------------------------------------
  logic [DIO_W-1:0] din_meta;
  logic [DIO_W-1:0] din_sync;
  logic [DIO_W-1:0] din_seen;

  wire logic [DIO_W-1:0] next_dout = (local_out & assigned) | (plc_dout & ~assigned);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= din_pin;
      din_sync <= din_meta;
    end
  end

  // Inputs and outputs move only on converter samples, which adds lag
  // relative to the controller's own scan.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      din_seen <= '0;
      dout_pin <= '0;
    end else if (adc_tick) begin
      din_seen <= din_sync;
      dout_pin <= next_dout;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (addr)
      OFS_CMD: rd_mux = cmd;
      OFS_CFG: rd_mux = {12'h000, order, fmt};
      OFS_STAT: rd_mux = stat_out;
      OFS_WORD1: rd_mux = data_out.first;
      OFS_WORD2: rd_mux = data_out.second;
      OFS_DOUT: rd_mux = 16'(plc_dout);
      OFS_DIN: rd_mux = 16'(din_seen);
      OFS_ASSIGN: rd_mux = 16'(assigned);
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? rd_mux : 16'h0000;
    end
  end

endmodule

// File: sim/wrf_checker.sv
// Concurrent checks on the register port and discrete outputs of the formatter.
module wrf_checker
  import wrf_pkg::*;
#(
  parameter int DIO_W = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Discrete I/O
  input wire logic adc_tick,
  input wire logic [DIO_W-1:0] local_out,
  input wire logic [DIO_W-1:0] dout_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh_cmd;
  logic [DIO_W-1:0] sh_dout;
  logic [DIO_W-1:0] sh_assign;
  wire logic mapped;
  wire logic [DIO_W-1:0] next_dout;
  assign mapped = (addr[1:0] == 2'h0) && (addr <= OFS_ASSIGN);
  assign next_dout = (wdata[DIO_W-1:0] & ~sh_assign) | (sh_dout & sh_assign);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sh_cmd <= 16'h0;
      sh_dout <= '0;
      sh_assign <= '0;
    end else if (wr) begin
      if (addr == OFS_CMD) sh_cmd <= wdata;
      if (addr == OFS_DOUT) sh_dout <= next_dout;
      if (addr == OFS_ASSIGN) sh_assign <= wdata[DIO_W-1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence read_of(logic [7:0] a);
    rd && addr == a;
  endsequence
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("read data seen without a read");
  unmapped_read_a: assert property (rd && !mapped |=> rdata == 16'h0)
    else $error("unmapped address read back nonzero");
  cmd_readback_a: assert property (read_of(OFS_CMD) |=> rdata == $past(sh_cmd))
    else $error("command word read back wrong");
  assign_readback_a: assert property (
    read_of(OFS_ASSIGN) |=> rdata[DIO_W-1:0] == $past(sh_assign))
    else $error("assignment mask read back wrong");
  dout_readback_a: assert property (
    read_of(OFS_DOUT) |=> rdata[DIO_W-1:0] == $past(sh_dout))
    else $error("controller outputs read back wrong");
  dout_hold_a: assert property (!adc_tick |=> $stable(dout_pin))
    else $error("outputs moved without a sample tick");
  dout_drive_a: assert property (
    adc_tick |=> dout_pin == (($past(local_out) & $past(sh_assign)) |
    ($past(sh_dout) & ~$past(sh_assign))))
    else $error("outputs not taken from owner");
  reset_quiet_a: assert property ($fell(rst) |-> dout_pin == '0 && rdata == 16'h0)
    else $error("outputs not quiet after reset");
endmodule
bind weight_report_rotation_formatter wrf_checker #(.DIO_W(DIO_W)) u_chk (.mclk(mclk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc_tick(adc_tick),
  .local_out(local_out), .dout_pin(dout_pin));

// File: sim/plc_model.sv
// Controller model that works the register port of the formatter.
module plc_model
  import wrf_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'hff;
    wdata = 16'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Idle address and data show the inverse of the last value, never a stale copy.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge mclk);
    d = rdata;
  endtask
  // A new command goes out once the acknowledge has reached the expected value, or after 100 status reads.
  task automatic command(input logic [15:0] code, input logic [7:0] ack, output logic [15:0] st);
    write_reg(OFS_CMD, code);
    st = 16'h0;
    for (int i = 0; i < 100 && st[15:8] !== ack; i++) begin
      read_reg(OFS_STAT, st);
    end
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench of the weight report formatter.
module tb
  import wrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UPD = 20;
  logic mclk, rst, wr, rd, adc_tick;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  field_src_t net_src, rate_src;
  logic [3:0] local_out, din_pin, dout_pin;
  int seed = 32'hca4ea1fe;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  weight_report_rotation_formatter #(.UPDATE_CYCLES(UPD), .DEPTH(8), .DIO_W(4)) u_dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .net_src(net_src), .rate_src(rate_src), .adc_tick(adc_tick), .local_out(local_out),
    .din_pin(din_pin), .dout_pin(dout_pin));
  plc_model u_plc (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  always #4 mclk = ~mclk;
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Sent words: byte swap acts inside words, word swap only on two-word floats.
  function automatic logic [31:0] exp_words(logic [1:0] f, logic [1:0] o, field_src_t s);
    logic [15:0] h;
    logic [15:0] l;
    h = (f == FMT_FLOAT) ? s.fp[31:16] : (f == FMT_DIVISIONS ? s.divs[15:0] : s.digits[15:0]);
    l = (f == FMT_FLOAT) ? s.fp[15:0] : 16'h0;
    if (o[1]) begin
      h = {h[7:0], h[15:8]};
      l = {l[7:0], l[15:8]};
    end
    exp_words = (f == FMT_FLOAT && o[0]) ? {l, h} : {h, l};
  endfunction
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    logic [15:0] d;
    logic [31:0] w;
    logic [1:0] f, o;
    logic [3:0] asg, pd, epin;
    mclk = 1'b0;
    rst = 1'b1;
    adc_tick = 1'b0;
    local_out = 4'h0;
    din_pin = 4'h0;
    net_src = '0;
    rate_src = '0;
    pd = 4'h0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    u_plc.read_reg(OFS_CFG, d);
    check("cfg", d, 16'h0);
    repeat (2 * UPD) @(posedge mclk);
    u_plc.read_reg(OFS_STAT, d);
    check("stat", d, {8'h00, IND_NULL});
    u_plc.read_reg(8'h20, d);
    check("unmapped", d, 16'h0);
    u_plc.command(CMD_CLEAR, ACK_FIRST, d);
    check("stat", d, {ACK_FIRST, IND_NULL});
    u_plc.command(CMD_ADD_NET, ACK_NEXT, d);
    check("stat", d, {ACK_NEXT, IND_NULL});
    u_plc.command(CMD_ADD_RATE, ACK_LAST, d);
    check("stat", d, {ACK_LAST, IND_NULL});
    net_src <= '{digits: $random(seed), divs: $random(seed), fp: $random(seed)};
    rate_src <= '{digits: $random(seed), divs: $random(seed), fp: $random(seed)};
    u_plc.command(CMD_FIRST, ACK_FIRST, d);
    check("stat", d, {ACK_FIRST, IND_NET});
    u_plc.read_reg(OFS_WORD1, d);
    check("word1", d, net_src.digits[15:0]);
    u_plc.write_reg(OFS_CMD, CMD_FIRST);
    net_src.digits <= $random(seed);
    repeat (3 * UPD) @(posedge mclk);
    u_plc.read_reg(OFS_STAT, d);
    check("stat", d, {ACK_FIRST, IND_NET});
    u_plc.read_reg(OFS_WORD1, d);
    check("word1", d, net_src.digits[15:0]);
    u_plc.command(CMD_NEXT, ACK_NEXT, d);
    check("stat", d, {ACK_NEXT, IND_RATE});
    u_plc.read_reg(OFS_WORD1, d);
    check("word1", d, rate_src.digits[15:0]);
    u_plc.write_reg(OFS_CMD, CMD_NEXT);
    repeat (3 * UPD) @(posedge mclk);
    u_plc.read_reg(OFS_STAT, d);
    check("stat", d, {ACK_NEXT, IND_RATE});
    u_plc.read_reg(OFS_CMD, d);
    check("cmd", d, CMD_NEXT);
    u_plc.command(CMD_FIRST, ACK_FIRST, d);
    check("stat", d, {ACK_FIRST, IND_NET});
    u_plc.command(CMD_NEXT, ACK_NEXT, d);
    check("stat", d, {ACK_NEXT, IND_RATE});
    for (int i = 0; i < 32; i++) begin
      f = i[1:0];
      o = i[3:2];
      if (i < 16) rate_src <= '{digits: 32'h054b, divs: 32'h054b, fp: 32'h44a96000};
      else rate_src <= '{digits: $random(seed), divs: $random(seed), fp: $random(seed)};
      u_plc.write_reg(OFS_CFG, {12'h0, o, f});
      repeat (3 * UPD) @(posedge mclk);
      w = exp_words(f, o, rate_src);
      u_plc.read_reg(OFS_WORD1, d);
      check("word1", d, w[31:16]);
      u_plc.read_reg(OFS_WORD2, d);
      check("word2", d, w[15:0]);
      u_plc.read_reg(OFS_STAT, d);
      check("stat", d, o[1] ? {IND_RATE, ACK_NEXT} : {ACK_NEXT, IND_RATE});
    end
    epin = 4'h0;
    for (int i = 0; i < 8; i++) begin
      asg = $random(seed);
      local_out <= $random(seed);
      din_pin <= $random(seed);
      d = $random(seed);
      u_plc.write_reg(OFS_ASSIGN, {12'h0, asg});
      u_plc.write_reg(OFS_DOUT, d);
      pd = (d[3:0] & ~asg) | (pd & asg);
      repeat (3) @(posedge mclk);
      check("dout_pin", {12'h0, dout_pin}, {12'h0, epin});
      adc_tick <= 1'b1;
      @(posedge mclk);
      adc_tick <= 1'b0;
      @(posedge mclk);
      epin = (local_out & asg) | (pd & ~asg);
      check("dout_pin", {12'h0, dout_pin}, {12'h0, epin});
      u_plc.read_reg(OFS_DIN, d);
      check("din", d, {12'h0, din_pin});
      u_plc.read_reg(OFS_DOUT, d);
      check("dout", d, {12'h0, pd});
      u_plc.read_reg(OFS_ASSIGN, d);
      check("assign", d, {12'h0, asg});
    end
    // A reset in mid-run must bring the outputs and settings back to idle.
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    check("dout_pin", {12'h0, dout_pin}, 16'h0);
    u_plc.read_reg(OFS_DOUT, d);
    check("dout", d, 16'h0);
    u_plc.read_reg(OFS_CFG, d);
    check("cfg", d, 16'h0);
    tally_and_finish();
  end
endmodule
